// ---- rtl/eebac_pkg.sv ----
package eebac_pkg;

  // ---------------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------------
  localparam int ADDR_W       = 7;
  localparam int WORD_W       = 8;
  localparam int DEPTH        = 128;

  // ---------------------------------------------------------------------------
  // Programming interval, in periods of the timing clock input
  // ---------------------------------------------------------------------------
  localparam int PROG_PERIODS = 1024;

  // ---------------------------------------------------------------------------
  // Control pins and their values after reset
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic write_n;
    logic addr_latch;
  } eebac_ctrl_t;

  localparam eebac_ctrl_t CTRL_IDLE  = '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1, addr_latch: 1'b0};
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic [WORD_W-1:0] DATA_RST = 8'h00;

endpackage : eebac_pkg

// ---- rtl/eebac_array.sv ----
`timescale 1ns/1ps
module eebac_array #(
  parameter int ADDR_W = eebac_pkg::ADDR_W,
  parameter int WORD_W = eebac_pkg::WORD_W,
  parameter int DEPTH  = eebac_pkg::DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [WORD_W-1:0] wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [WORD_W-1:0] rd_data
);

  // Storage has no reset, like the cells it stands for.
  logic [WORD_W-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= eebac_pkg::DATA_RST;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : eebac_array

// ---- rtl/eebac_timer.sv ----
`timescale 1ns/1ps
module eebac_timer #(
  parameter int PERIODS = eebac_pkg::PROG_PERIODS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic tick,
  output logic      running,
  output logic      done
);

  localparam int CNT_W = $clog2(PERIODS + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIODS - 1);

  logic [CNT_W-1:0] count;
  logic             last_tick;

  assign last_tick = running && tick && (count == LAST);

  // ---------------------------------------------------------------------------
  // Period counter
  // ---------------------------------------------------------------------------
  // Each tick is one rising edge of the timing clock, so the interval scales
  // with whatever RC network or clock the board puts there.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count   <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done <= last_tick;
      if (start)
      begin
        count   <= '0;
        running <= 1'b1;
      end
      else if (last_tick)
      begin
        running <= 1'b0;
      end
      else if (running && tick)
      begin
        count <= count + 1'b1;
      end
    end
  end

  a_period_end : assert property (@(posedge clk) disable iff (!rst_n) last_tick |=> !running && done)
    else $error("timer did not stop after the last period");
  a_no_early_end : assert property (@(posedge clk) disable iff (!rst_n) (running && !last_tick) |=> running)
    else $error("timer stopped before the last period");

endmodule : eebac_timer

// ---- rtl/eebac_top.sv ----
`timescale 1ns/1ps
// Operation
// - 128 words of 8 bits, one word chosen by a 7-bit word select.
// - Chip select high floats the byte bus and keeps standby.
// - Write strobe is ignored while chip select is high.
// - Chip select and output enable low, write high, drive stored byte.
// - Chip select low, output enable and write high: bus floats, no access.
// - Word select is latched on the falling edge of the address strobe.
// - Low write pulse starts programming; data taken on its rising edge.
// - Multiplexed: address latched on strobe fall, data on write rise.
// - Ready low while programming, high otherwise.
// - Programming length is paced by the timing clock input.
// - Address and data are held inside and the write completes alone.
// - Programming lasts 1024 timing clock periods with ready low.
// - All bus and strobe inputs are ignored while programming runs.
// - Read byte stays driven until output enable or chip select rises.
module eebac_top #(
  parameter int PROG_PERIODS = eebac_pkg::PROG_PERIODS
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic [eebac_pkg::ADDR_W-1:0]  word_select,
  input  wire logic [eebac_pkg::WORD_W-1:0]  byte_bus_in,
  output logic      [eebac_pkg::WORD_W-1:0]  byte_bus_out,
  output logic                               byte_bus_oe,
  input  wire logic                          chip_sel_n,
  input  wire logic                          out_en_n,
  input  wire logic                          write_n,
  input  wire logic                          addr_latch,
  input  wire logic                          timing_clk,
  output logic                               ready
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_PROG
  } eebac_state_t;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Every pin is asynchronous to clk. Address, data and controls pass through
  // the same depth, so a strobe edge seen here lines up with the bus values
  // that stood beside it at the pins.
  eebac_pkg::eebac_ctrl_t         ctrl_s1;
  eebac_pkg::eebac_ctrl_t         ctrl_s2;
  eebac_pkg::eebac_ctrl_t         ctrl_d;
  logic [eebac_pkg::ADDR_W-1:0]   word_s1;
  logic [eebac_pkg::ADDR_W-1:0]   word_s2;
  logic [eebac_pkg::WORD_W-1:0]   data_s1;
  logic [eebac_pkg::WORD_W-1:0]   data_s2;
  logic                           tclk_s1;
  logic                           tclk_s2;
  logic                           tclk_d;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_s1 <= eebac_pkg::CTRL_IDLE;
      ctrl_s2 <= eebac_pkg::CTRL_IDLE;
      ctrl_d  <= eebac_pkg::CTRL_IDLE;
    end
    else
    begin
      ctrl_s1 <= '{chip_sel_n: chip_sel_n, out_en_n: out_en_n, write_n: write_n, addr_latch: addr_latch};
      ctrl_s2 <= ctrl_s1;
      ctrl_d  <= ctrl_s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_s1 <= eebac_pkg::ADDR_RST;
      word_s2 <= eebac_pkg::ADDR_RST;
      data_s1 <= eebac_pkg::DATA_RST;
      data_s2 <= eebac_pkg::DATA_RST;
    end
    else
    begin
      word_s1 <= word_select;
      word_s2 <= word_s1;
      data_s1 <= byte_bus_in;
      data_s2 <= data_s1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tclk_s1 <= 1'b0;
      tclk_s2 <= 1'b0;
      tclk_d  <= 1'b0;
    end
    else
    begin
      tclk_s1 <= timing_clk;
      tclk_s2 <= tclk_s1;
      tclk_d  <= tclk_s2;
    end
  end

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  eebac_state_t                   state;
  logic [eebac_pkg::ADDR_W-1:0]   addr;
  logic [eebac_pkg::WORD_W-1:0]   prog_data;
  logic [eebac_pkg::WORD_W-1:0]   rd_data;
  logic                           we_fall;
  logic                           we_rise;
  logic                           start_prog;
  logic                           read_mode;
  logic                           tclk_tick;
  logic                           timer_running;
  logic                           timer_done;

  assign we_fall    = ctrl_d.write_n && !ctrl_s2.write_n;
  assign we_rise    = !ctrl_d.write_n && ctrl_s2.write_n;
  assign tclk_tick  = tclk_s2 && !tclk_d;
  assign start_prog = (state == ST_ARMED) && we_rise && !ctrl_s2.chip_sel_n;
  assign read_mode  = (state == ST_IDLE) && !ctrl_s2.chip_sel_n && !ctrl_s2.out_en_n
                      && ctrl_s2.write_n;

  // ---------------------------------------------------------------------------
  // Write sequencer
  // ---------------------------------------------------------------------------
  // A write strobe that falls is only armed; chip select rising before the
  // strobe returns abandons it, so a stray strobe from a deselected host is
  // harmless.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (we_fall && !ctrl_s2.chip_sel_n)
          begin
            state <= ST_ARMED;
          end
        end
        ST_ARMED:
        begin
          if (ctrl_s2.chip_sel_n)
          begin
            state <= ST_IDLE;
          end
          else if (start_prog)
          begin
            state <= ST_PROG;
          end
        end
        ST_PROG:
        begin
          if (timer_done)
          begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Address latch and data hold
  // ---------------------------------------------------------------------------
  // The latch follows the word select while the strobe is high and freezes
  // on its fall. With the strobe tied to the write strobe on separate buses,
  // it is transparent throughout a read, which is what that mode expects.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr <= eebac_pkg::ADDR_RST;
    end
    else if (ctrl_s2.addr_latch && (state != ST_PROG))
    begin
      addr <= word_s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_data <= eebac_pkg::DATA_RST;
    end
    else if (start_prog)
    begin
      prog_data <= data_s2;
    end
  end

  eebac_array #(
    .ADDR_W (eebac_pkg::ADDR_W),
    .WORD_W (eebac_pkg::WORD_W),
    .DEPTH  (eebac_pkg::DEPTH)
  ) u_array (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (start_prog),
    .wr_addr (addr),
    .wr_data (data_s2),
    .rd_addr (addr),
    .rd_data (rd_data)
  );

  eebac_timer #(
    .PERIODS (PROG_PERIODS)
  ) u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (start_prog),
    .tick    (tclk_tick),
    .running (timer_running),
    .done    (timer_done)
  );

  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  // The bus enable drops in the cycle after chip select or output enable is
  // seen high, giving the host a clean turnaround on a shared bus.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_bus_oe  <= 1'b0;
      byte_bus_out <= eebac_pkg::DATA_RST;
    end
    else
    begin
      byte_bus_oe  <= read_mode;
      byte_bus_out <= rd_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready <= 1'b1;
    end
    else
    begin
      ready <= !(start_prog || ((state == ST_PROG) && !timer_done));
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_standby_float : assert property (@(posedge clk) disable iff (!rst_n) ctrl_s2.chip_sel_n |=> !byte_bus_oe)
    else $error("byte bus driven while chip select high");
  a_write_gated : assert property (@(posedge clk) disable iff (!rst_n)
    ((state == ST_IDLE) && ctrl_s2.chip_sel_n && we_fall) |=> (state == ST_IDLE))
    else $error("write strobe armed while deselected");
  a_read_drive : assert property (@(posedge clk) disable iff (!rst_n)
    read_mode |=> byte_bus_oe && (byte_bus_out == $past(rd_data)))
    else $error("read did not drive the stored byte");
  a_inhibit_float : assert property (@(posedge clk) disable iff (!rst_n)
    (!ctrl_s2.chip_sel_n && ctrl_s2.out_en_n && ctrl_s2.write_n) |=> !byte_bus_oe)
    else $error("byte bus driven in inhibit mode");
  a_addr_capture : assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_s2.addr_latch && (state != ST_PROG)) |=> (addr == $past(word_s2)))
    else $error("word select not taken while strobe high");
  a_addr_hold : assert property (@(posedge clk) disable iff (!rst_n) !ctrl_s2.addr_latch |=> $stable(addr))
    else $error("address changed after strobe fell");
  a_prog_start : assert property (@(posedge clk) disable iff (!rst_n)
    start_prog |=> (state == ST_PROG) && !ready && (prog_data == $past(data_s2)))
    else $error("programming did not start on write rise");
  a_busy_low : assert property (@(posedge clk) disable iff (!rst_n)
    ((state == ST_PROG) && !timer_done) |=> !ready)
    else $error("ready high during programming");
  a_ready_return : assert property (@(posedge clk) disable iff (!rst_n)
    ((state == ST_PROG) && timer_done) |=> ready && (state == ST_IDLE))
    else $error("ready did not return after programming");
  a_inputs_ignored : assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_PROG) |=> !byte_bus_oe && $stable(addr) && $stable(prog_data))
    else $error("inputs acted on during programming");
  a_read_release : assert property (@(posedge clk) disable iff (!rst_n)
    (byte_bus_oe && (ctrl_s2.out_en_n || ctrl_s2.chip_sel_n)) |=> !byte_bus_oe)
    else $error("byte bus held after read ended");
  a_timer_sync : assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_PROG) |-> timer_running || timer_done)
    else $error("programming without running timer");

  c_write_done : cover property (@(posedge clk) disable iff (!rst_n) (state == ST_PROG) ##1 ready);
  c_read : cover property (@(posedge clk) disable iff (!rst_n) read_mode ##1 byte_bus_oe);
  c_mux_write : cover property (@(posedge clk) disable iff (!rst_n)
    ctrl_s2.addr_latch ##1 !ctrl_s2.addr_latch ##[1:20] start_prog);
  c_abort : cover property (@(posedge clk) disable iff (!rst_n) (state == ST_ARMED) && ctrl_s2.chip_sel_n);

endmodule : eebac_top

// ---- dv/eebac_host.sv ----
`timescale 1ns/1ps
module eebac_host (
  input  wire logic                         clk,
  input  wire logic [eebac_pkg::WORD_W-1:0] byte_bus_out,
  input  wire logic                         byte_bus_oe,
  output logic      [eebac_pkg::ADDR_W-1:0] word_select,
  output logic      [eebac_pkg::WORD_W-1:0] byte_bus_in,
  output logic                              chip_sel_n,
  output logic                              out_en_n,
  output logic                              write_n,
  output logic                              addr_latch,
  output logic                              timing_clk
);
  logic                         tie;
  logic                         ale;
  logic [eebac_pkg::WORD_W-1:0] drv;

  // ---------------------------------------------------------------------------
  // Pin wiring
  // ---------------------------------------------------------------------------
  // With separate buses the address strobe is wired to the write strobe.
  assign addr_latch  = tie ? write_n : ale;
  // A released bus shows the inverse of the last byte, never a stale copy.
  assign byte_bus_in = byte_bus_oe ? byte_bus_out : drv;

  initial
  begin
    word_select = 7'h00;
    drv         = 8'h00;
    chip_sel_n  = 1'b1;
    out_en_n    = 1'b1;
    write_n     = 1'b1;
    ale         = 1'b0;
    tie         = 1'b1;
    timing_clk  = 1'b0;
  end

  // The timing input runs free, like an RC oscillator, at one twentieth of clk.
  always
  begin
    repeat (10) @(posedge clk);
    timing_clk <= ~timing_clk;
  end

  // ---------------------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic write(input logic mux, input logic sel, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    tie         <= ~mux;
    chip_sel_n  <= ~sel;
    word_select <= a;
    ale         <= mux;
    if (!mux)
      drv <= d;
    wt(4);
    if (mux)
    begin
      ale         <= 1'b0;
      wt(4);
      word_select <= ~a;
      drv         <= d;
      wt(4);
    end
    write_n <= 1'b0;
    wt(6);
    write_n <= 1'b1;
    wt(4);
    chip_sel_n <= 1'b1;
    drv        <= ~d;
  endtask : write

  task automatic read(input logic sel, input logic oe, input logic [6:0] a,
                      output logic [7:0] q, output logic on, output logic off);
    @(posedge clk);
    tie         <= 1'b1;
    chip_sel_n  <= ~sel;
    word_select <= a;
    // The address settles through the latch and array before output enable
    // falls, so the bus never carries a byte from an unwritten passing address.
    wt(4);
    out_en_n <= ~oe;
    wt(8);
    #1;
    q  = byte_bus_out;
    on = byte_bus_oe;
    wt(1);
    out_en_n <= 1'b1;
    wt(4);
    #1;
    off = byte_bus_oe;
    wt(1);
    chip_sel_n <= 1'b1;
    wt(2);
  endtask : read
endmodule : eebac_host

// ---- dv/eebac_top_bench.sv ----
`timescale 1ns/1ps
module eebac_top_bench;
  localparam int PROG = 4;
  logic                         clk;
  logic                         rst_n;
  logic [eebac_pkg::ADDR_W-1:0] word_select;
  logic [eebac_pkg::WORD_W-1:0] byte_bus_in;
  logic [eebac_pkg::WORD_W-1:0] byte_bus_out;
  logic                         byte_bus_oe;
  logic                         chip_sel_n;
  logic                         out_en_n;
  logic                         write_n;
  logic                         addr_latch;
  logic                         timing_clk;
  logic                         ready;
  int                           mismatches = 0;
  int                           checks_done = 0;

  eebac_top #(.PROG_PERIODS(PROG)) dut (
    .clk(clk), .rst_n(rst_n), .word_select(word_select), .byte_bus_in(byte_bus_in),
    .byte_bus_out(byte_bus_out), .byte_bus_oe(byte_bus_oe), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_n(write_n), .addr_latch(addr_latch),
    .timing_clk(timing_clk), .ready(ready)
  );

  eebac_host host (
    .clk(clk), .byte_bus_out(byte_bus_out), .byte_bus_oe(byte_bus_oe),
    .word_select(word_select), .byte_bus_in(byte_bus_in), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_n(write_n), .addr_latch(addr_latch), .timing_clk(timing_clk)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // Counts clock cycles until ready returns, bounded so a stuck flag fails.
  task automatic busy_len(output int n);
    n = 0;
    while (ready !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : busy_len

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_write_sep;
    int n;
    logic [7:0] q;
    logic on, off;
    host.write(1'b0, 1'b1, 7'h05, 8'hA5);
    chk({7'h00, ready}, 8'h00);
    busy_len(n);
    chk({7'h00, n > (PROG-1)*20-4 && n <= PROG*20+4}, 8'h01);
    host.read(1'b1, 1'b1, 7'h05, q, on, off);
    chk(q, 8'hA5);
    chk({6'h00, on, off}, 8'h02);
  endtask : t_write_sep

  task automatic t_write_mux;
    int n;
    logic [7:0] q;
    logic on, off;
    host.write(1'b1, 1'b1, 7'h7F, 8'h3C);
    busy_len(n);
    chk({7'h00, n > (PROG-1)*20-4 && n <= PROG*20+4}, 8'h01);
    chk({7'h00, ready}, 8'h01);
    host.read(1'b1, 1'b1, 7'h7F, q, on, off);
    chk(q, 8'h3C);
    host.read(1'b1, 1'b1, 7'h05, q, on, off);
    chk(q, 8'hA5);
  endtask : t_write_mux

  task automatic t_gating;
    logic [7:0] q;
    logic on, off;
    host.read(1'b1, 1'b0, 7'h05, q, on, off);
    chk({7'h00, on}, 8'h00);
    host.read(1'b0, 1'b1, 7'h05, q, on, off);
    chk({6'h00, on, ready}, 8'h01);
    host.write(1'b0, 1'b0, 7'h05, 8'h5A);
    host.wt(4);
    chk({7'h00, ready}, 8'h01);
    host.read(1'b1, 1'b1, 7'h05, q, on, off);
    chk(q, 8'hA5);
    chk({7'h00, on}, 8'h01);
  endtask : t_gating

  task automatic t_busy;
    int n;
    logic [7:0] q;
    logic on, off;
    host.write(1'b0, 1'b1, 7'h05, 8'h11);
    host.read(1'b1, 1'b1, 7'h05, q, on, off);
    chk({7'h00, on}, 8'h00);
    host.write(1'b0, 1'b1, 7'h7F, 8'h99);
    busy_len(n);
    host.read(1'b1, 1'b1, 7'h05, q, on, off);
    chk(q, 8'h11);
    host.read(1'b1, 1'b1, 7'h7F, q, on, off);
    chk(q, 8'h3C);
  endtask : t_busy

  // ---------------------------------------------------------------------------
  // Sequence and watchdog
  // ---------------------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    host.wt(2);
    t_write_sep();
    t_write_mux();
    t_gating();
    t_busy();
    wrap_up();
  end

  // The whole run needs well under 1000 cycles; this margin only catches a hang.
  initial
  begin
    #100us;
    mismatches++;
    wrap_up();
  end
endmodule : eebac_top_bench
